// >>> core/smsp_clkdiv.sv
// master sck half-period divider producing a one-cycle tick enable
`timescale 1ns/1ps
module smsp_clkdiv import smsp_pkg::*; #(
  parameter int unsigned CW = SMSP_HALF_W // half-period counter width
) (
  input  wire logic          ref_clk,     // 25 MHz clock
  input  wire logic          rst_n,       // async reset, active low
  input  wire logic          run,         // count while high
  input  wire logic [CW-1:0] half_cycles, // cycles per sck half period
  output logic               tick         // one-cycle pulse per half period
);

  logic [CW-1:0] cnt_q;                   // cycles into current half period
  logic [CW-1:0] cnt_d;                   // next count

  // restart from zero whenever stopped so the first edge is a full half period
  always_comb begin
    tick  = run && (cnt_q == half_cycles - CW'(1));
    cnt_d = cnt_q + CW'(1);
    if (!run || tick) begin
      cnt_d = '0;
    end
  end

  // count register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// >>> core/smsp_core.sv
// master/slave serial port: shift engine, flags, pin direction control
`timescale 1ns/1ps
module smsp_core import smsp_pkg::*; #(
  parameter int unsigned DW = SMSP_DW        // transfer width
) (
  input  wire logic          ref_clk,            // 25 MHz clock
  input  wire logic          rst_n,              // async reset, active low
  input  wire logic          port_enable,        // port on
  input  wire logic          master_select_wr,   // software writes master_select
  input  wire logic          master_select_wdata,// value written
  input  wire logic          bit_order_select,   // 1: lsb first
  input  wire logic          clock_polarity,     // idle sck level
  input  wire logic          clock_phase,        // 1: sample on trailing edge
  input  wire logic [1:0]    rate_select,        // master rate code
  input  wire logic          double_speed_bit,   // halve master divisor
  input  wire logic          transfer_irq_enable,// completion interrupt enable
  input  wire logic          global_irq_enable,  // global enable from cpu_status_word
  input  wire logic          irq_ack,            // vector taken, pulse
  input  wire logic          status_rd,          // status register read, pulse
  input  wire logic          data_rd,            // data register read, pulse
  input  wire logic          data_wr,            // data register write, pulse
  input  wire logic [DW-1:0] data_wdata,         // byte written
  output logic      [DW-1:0] data_rdata,         // receive buffer
  output logic               master_select,      // current master mode bit
  output logic               transfer_complete_flag, // completion flag
  output logic               write_collision_flag,   // collision flag
  output logic               irq_req,            // interrupt request level
  input  wire logic          ddr_mosi,           // user direction, 1 = output
  input  wire logic          ddr_miso,           // user direction, 1 = output
  input  wire logic          ddr_sck,            // user direction, 1 = output
  input  wire logic          ddr_ss,             // user direction, 1 = output
  input  wire logic          ss_gpio_level,      // level for select pin as output
  input  wire logic          sck_in,             // sck pin level
  output logic               sck_out,            // sck drive value
  output logic               sck_oe_n,           // low while driving sck
  input  wire logic          mosi_in,            // mosi pin level
  output logic               mosi_out,           // mosi drive value
  output logic               mosi_oe_n,          // low while driving mosi
  input  wire logic          miso_in,            // miso pin level
  output logic               miso_out,           // miso drive value
  output logic               miso_oe_n,          // low while driving miso
  input  wire logic          ss_in,              // select pin level, active low
  output logic               ss_out,             // select drive value
  output logic               ss_oe_n             // low while driving select
);

  smsp_state_t     state_q, state_d;       // engine state
  logic            master_q, master_d;     // master mode bit
  logic [DW-1:0]   sr_q, sr_d;             // shift register
  logic [DW-1:0]   rx_buf_q, rx_buf_d;     // receive buffer
  logic            out_q, out_d;           // serial output bit
  logic            sck_q, sck_d;           // master sck level
  logic            sck_prev_q, sck_prev_d; // last sampled sck, slave edge detect
  logic [2:0]      bit_cnt_q, bit_cnt_d;   // bits sampled in this byte
  logic            transfer_complete_flag_q, transfer_complete_flag_d;         // completion flag
  logic            write_collision_flag_q, write_collision_flag_d;         // collision flag
  logic            armed_q, armed_d;       // status read seen with a flag set

  logic [SMSP_HALF_W-1:0] half_cyc;        // selected half period
  logic                   tick;            // master half-period enable
  logic                   run;             // divider running

  // rate table, double speed halves each divisor
  always_comb begin
    case (rate_select)
      2'b00:   half_cyc = SMSP_HALF_R0;
      2'b01:   half_cyc = SMSP_HALF_R1;
      2'b10:   half_cyc = SMSP_HALF_R2;
      default: half_cyc = SMSP_HALF_R3;
    endcase
    if (double_speed_bit) begin
      half_cyc = half_cyc >> 1;
    end
  end

  assign run = port_enable && master_q && (state_q == SMSP_SHIFT);

  smsp_clkdiv #(
    .CW (SMSP_HALF_W)
  ) u_div (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .run         (run),
    .half_cycles (half_cyc),
    .tick        (tick)
  );

  // next-state logic for engine, flags and buffers
  always_comb begin
    logic          slave_act;  // selected slave
    logic          mode_fault; // another master pulled select low
    logic          edge_v;     // an sck edge to act on
    logic          lead;       // edge is the leading one
    logic          sample;     // sampling edge
    logic          setup;      // output change edge
    logic          in_bit;     // incoming serial bit
    logic          clr;        // flag clear sequence completes
    logic [DW-1:0] sr_n;       // shift register after sampling
    slave_act  = 1'b0;
    mode_fault = 1'b0;
    edge_v     = 1'b0;
    lead       = 1'b0;
    sample     = 1'b0;
    setup      = 1'b0;
    in_bit     = 1'b0;
    clr        = 1'b0;
    sr_n       = sr_q;

    state_d    = state_q;
    master_d   = master_q;
    sr_d       = sr_q;
    rx_buf_d   = rx_buf_q;
    out_d      = out_q;
    sck_d      = sck_q;
    sck_prev_d = sck_in;
    bit_cnt_d  = bit_cnt_q;
    transfer_complete_flag_d     = transfer_complete_flag_q;
    write_collision_flag_d     = write_collision_flag_q;
    armed_d    = armed_q;

    // clears go first so any set below in the same cycle wins
    clr = armed_q && (data_rd || data_wr);
    if (clr) begin
      transfer_complete_flag_d  = 1'b0;
      write_collision_flag_d  = 1'b0;
      armed_d = 1'b0;
    end else if (status_rd && (transfer_complete_flag_q || write_collision_flag_q)) begin
      armed_d = 1'b1;
    end
    if (irq_ack) begin
      transfer_complete_flag_d = 1'b0;
    end

    slave_act  = port_enable && !master_q && !ss_in;
    mode_fault = port_enable && master_q && !ddr_ss && !ss_in;
    if (master_q) begin
      edge_v = run && tick;
      lead   = (sck_q == clock_polarity);
      in_bit = miso_in;
    end else begin
      edge_v = slave_act && (sck_in != sck_prev_q);
      lead   = (sck_prev_q == clock_polarity);
      in_bit = mosi_in;
    end
    sample = edge_v && (lead != clock_phase);
    setup  = edge_v && (lead == clock_phase);
    if (bit_order_select) begin
      sr_n = {in_bit, sr_q[DW-1:1]};
    end else begin
      sr_n = {sr_q[DW-2:0], in_bit};
    end

    if (master_select_wr) begin
      master_d  = master_select_wdata;
      state_d   = SMSP_IDLE;
      bit_cnt_d = SMSP_CNT_RST;
    end

    if (!port_enable) begin
      // disabled: engine parked, counter cleared
      state_d   = SMSP_IDLE;
      bit_cnt_d = SMSP_CNT_RST;
      sck_d     = clock_polarity;
    end else if (mode_fault) begin
      // drop to slave, abort any master byte
      master_d  = 1'b0;
      state_d   = SMSP_IDLE;
      bit_cnt_d = SMSP_CNT_RST;
      sck_d     = clock_polarity;
      transfer_complete_flag_d    = 1'b1;
    end else if (!master_q && ss_in) begin
      // deselected slave: counter and engine reset at once
      state_d   = SMSP_IDLE;
      bit_cnt_d = SMSP_CNT_RST;
    end else begin
      if (sample) begin
        sr_d      = sr_n;
        bit_cnt_d = bit_cnt_q + SMSP_CNT_ONE;
        state_d   = SMSP_SHIFT;
        if (!master_q && (bit_cnt_d == SMSP_CNT_RST)) begin
          rx_buf_d = sr_n;
          transfer_complete_flag_d   = 1'b1;
          state_d  = SMSP_IDLE;
        end
      end
      if (setup) begin
        out_d = bit_order_select ? sr_q[0] : sr_q[DW-1];
      end
      if (master_q && edge_v) begin
        sck_d = ~sck_q;
        // trailing edge at or after the eighth sample ends the byte
        if (!lead && (bit_cnt_d == SMSP_CNT_RST)) begin
          rx_buf_d = sample ? sr_n : sr_q;
          transfer_complete_flag_d   = 1'b1;
          state_d  = SMSP_IDLE;
        end
      end
      if (master_q && (state_q == SMSP_IDLE)) begin
        sck_d = clock_polarity;
      end
    end

    // data write: load when quiet, otherwise refuse and flag
    if (data_wr) begin
      if (state_q == SMSP_SHIFT) begin
        write_collision_flag_d = 1'b1;
      end else begin
        sr_d  = data_wdata;
        out_d = bit_order_select ? data_wdata[0] : data_wdata[DW-1];
        if (master_q && port_enable && !mode_fault && !master_select_wr) begin
          state_d   = SMSP_SHIFT;
          bit_cnt_d = SMSP_CNT_RST;
          sck_d     = clock_polarity;
        end
      end
    end
  end

  // state registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= SMSP_IDLE;
      master_q   <= 1'b0;
      sr_q       <= SMSP_BYTE_RST;
      rx_buf_q   <= SMSP_BYTE_RST;
      out_q      <= 1'b0;
      sck_q      <= 1'b0;
      sck_prev_q <= 1'b0;
      bit_cnt_q  <= SMSP_CNT_RST;
      transfer_complete_flag_q     <= 1'b0;
      write_collision_flag_q     <= 1'b0;
      armed_q    <= 1'b0;
    end else begin
      state_q    <= state_d;
      master_q   <= master_d;
      sr_q       <= sr_d;
      rx_buf_q   <= rx_buf_d;
      out_q      <= out_d;
      sck_q      <= sck_d;
      sck_prev_q <= sck_prev_d;
      bit_cnt_q  <= bit_cnt_d;
      transfer_complete_flag_q     <= transfer_complete_flag_d;
      write_collision_flag_q     <= write_collision_flag_d;
      armed_q    <= armed_d;
    end
  end

  // pin direction overrides; disabled port releases all but a gpio select
  always_comb begin
    sck_oe_n  = 1'b1;
    mosi_oe_n = 1'b1;
    miso_oe_n = 1'b1;
    ss_oe_n   = !ddr_ss;
    if (port_enable && master_q) begin
      sck_oe_n  = !ddr_sck;
      mosi_oe_n = !ddr_mosi;
    end else if (port_enable) begin
      ss_oe_n   = 1'b1;
      miso_oe_n = !(ddr_miso && !ss_in);
    end
  end

  assign sck_out  = sck_q;
  assign mosi_out = out_q;
  assign miso_out = out_q;
  assign ss_out   = ss_gpio_level;

  assign data_rdata             = rx_buf_q;
  assign master_select          = master_q;
  assign transfer_complete_flag = transfer_complete_flag_q;
  assign write_collision_flag   = write_collision_flag_q;
  // both enables gate the request, also for the forced-slave event
  assign irq_req = transfer_complete_flag_q && transfer_irq_enable && global_irq_enable;

endmodule

// >>> core/smsp_pkg.sv
// shared constants and types for the byte-wide serial port
package smsp_pkg;

  localparam int unsigned SMSP_DW      = 8;      // bits per transfer
  localparam int unsigned SMSP_CNT_W   = 3;      // bit counter width
  localparam int unsigned SMSP_HALF_W  = 7;      // half-period counter width

  // sck half periods in ref_clk cycles, normal speed (rate codes 00..11)
  localparam logic [6:0]  SMSP_HALF_R0 = 7'h02;  // divide by 4
  localparam logic [6:0]  SMSP_HALF_R1 = 7'h08;  // divide by 16
  localparam logic [6:0]  SMSP_HALF_R2 = 7'h20;  // divide by 64
  localparam logic [6:0]  SMSP_HALF_R3 = 7'h40;  // divide by 128

  localparam logic [7:0]  SMSP_BYTE_RST = 8'h00; // shift and receive reset value
  localparam logic [2:0]  SMSP_CNT_RST  = 3'h0;  // bit counter reset value
  localparam logic [2:0]  SMSP_CNT_ONE  = 3'h1;  // bit counter step

  // shift engine state
  typedef enum logic {
    SMSP_IDLE,
    SMSP_SHIFT
  } smsp_state_t;

endpackage

// >>> verification/smsp_core_monitor.sv
// assertion checker on the serial port top ports
`timescale 1ns/1ps
module smsp_core_monitor (
  input wire logic       ref_clk,                // clock
  input wire logic       rst_n,                  // reset, active low
  input wire logic       port_enable,            // port on
  input wire logic       master_select,          // mode bit
  input wire logic       transfer_complete_flag, // done flag
  input wire logic       write_collision_flag,   // collision flag
  input wire logic       irq_req,                // request level
  input wire logic       transfer_irq_enable,    // local enable
  input wire logic       global_irq_enable,      // global enable
  input wire logic       irq_ack,                // vector taken
  input wire logic       data_wr,                // data write
  input wire logic       ddr_ss,                 // select direction
  input wire logic       ss_gpio_level,          // gpio level
  input wire logic       ss_in,                  // select pin
  input wire logic       ss_out,                 // select drive
  input wire logic       ss_oe_n,                // select enable
  input wire logic       sck_out,                // sck drive
  input wire logic       sck_oe_n,               // sck enable
  input wire logic       mosi_oe_n,              // mosi enable
  input wire logic       miso_oe_n,              // miso enable
  input wire logic [1:0] rate_select,            // rate code
  input wire logic       double_speed_bit        // double speed
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic fast; // master at the quickest normal rate
  assign fast = master_select && rate_select == 2'b00 && !double_speed_bit;
  // a fresh start, and a second write hard behind it
  sequence s_start; fast && data_wr && !transfer_complete_flag; endsequence
  sequence s_twice; fast && data_wr ##1 fast && data_wr; endsequence
  a_byte_done_time: assert property (s_start |=> !transfer_complete_flag [*8] ##[23:26]
    transfer_complete_flag) else $error("byte completion out of time");
  a_collide_set: assert property (s_twice |=> write_collision_flag)
    else $error("write during transfer not flagged");
  a_mode_fault: assert property (master_select && !ddr_ss && !ss_in && port_enable
    |=> !master_select && transfer_complete_flag) else $error("mode fault missed");
  a_irq_gate: assert property (irq_req == (transfer_complete_flag &&
    transfer_irq_enable && global_irq_enable)) else $error("irq request wrong");
  a_ack_clear: assert property (irq_ack && !master_select && ss_in
    |=> !transfer_complete_flag) else $error("ack left flag set");
  a_miso_quiet: assert property (!master_select && ss_in |-> miso_oe_n)
    else $error("miso driven while deselected");
  a_master_miso_in: assert property (master_select |-> miso_oe_n)
    else $error("miso driven in master mode");
  a_slave_inputs: assert property (port_enable && !master_select
    |-> sck_oe_n && mosi_oe_n && ss_oe_n) else $error("slave pin driven");
  a_ss_gpio: assert property (master_select && ddr_ss
    |-> !ss_oe_n && ss_out == ss_gpio_level) else $error("select gpio wrong");
  // a half period at this rate is two cycles, so no toggle follows another
  a_sck_rate: assert property (fast && $changed(sck_out) |=> $stable(sck_out))
    else $error("sck toggled too fast");
endmodule

// >>> verification/smsp_core_test.sv
// self-checking bench for the master/slave serial port
`timescale 1ns/1ps
bind smsp_core smsp_core_monitor mon (.*);
module smsp_core_test;
  logic       ref_clk = 0, rst_n = 0, port_enable, master_select_wr, master_select_wdata;
  logic       bit_order_select, clock_polarity, clock_phase, double_speed_bit;
  logic       transfer_irq_enable, global_irq_enable, irq_ack, status_rd, data_rd, data_wr;
  logic [1:0] rate_select;
  logic [7:0] data_wdata, data_rdata, rx;
  logic       master_select, transfer_complete_flag, write_collision_flag, irq_req;
  logic       ddr_mosi, ddr_miso, ddr_sck, ddr_ss, ss_gpio_level;
  logic       sck_in, sck_out, sck_oe_n, mosi_in, mosi_out, mosi_oe_n;
  logic       miso_in, miso_out, miso_oe_n, ss_in, ss_out, ss_oe_n;
  logic       p_sck, p_mosi, p_ss_n, p_miso;
  int         err_count = 0, checks_done = 0, n;
  int         hv[4] = '{2, 8, 32, 64}; // sck half periods, divisor over two
  always #20 ref_clk = ~ref_clk;
  // a pin shows the device while it drives, else the peer
  assign sck_in  = sck_oe_n  ? p_sck  : sck_out;
  assign mosi_in = mosi_oe_n ? p_mosi : mosi_out;
  assign miso_in = miso_oe_n ? p_miso : miso_out;
  assign ss_in   = ss_oe_n   ? p_ss_n : ss_out;
  smsp_core dut (.*);
  smsp_peer peer (.ref_clk, .sck(sck_in), .mosi(mosi_in), .ss_n(ss_in), .miso(miso_in),
    .sck_o(p_sck), .mosi_o(p_mosi), .ss_n_o(p_ss_n), .miso_o(p_miso));
  function automatic logic [7:0] rev(input logic [7:0] b);
    for (int k = 0; k < 8; k++) rev[k] = b[7 - k];
  endfunction
  task automatic chk8(input logic [7:0] e, g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t byte %h want %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic e, g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t bit %b want %b", $time, g, e);
    end
  endtask
  task automatic chkn(input int e, g);
    checks_done++;
    if (g != e) begin
      err_count++;
      $display("[ERR] %0t cycles %0d want %0d", $time, g, e);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge ref_clk);
    s = 1'b0;
  endtask
  task automatic wr(input logic [7:0] b);
    data_wdata = b;
    pulse(data_wr);
  endtask
  // counts cycles until the done flag, bounded
  task automatic wait_done;
    n = 0;
    while (transfer_complete_flag !== 1'b1 && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
    chk1(1'b1, transfer_complete_flag);
  endtask
  task automatic conclude;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // watchdog well beyond the longest expected run
  initial begin
    #(40 * 20000);
    err_count++;
    conclude();
  end
  initial begin
    {port_enable, master_select_wr, bit_order_select, clock_polarity, clock_phase} = '0;
    {double_speed_bit, irq_ack, status_rd, data_rd, data_wr, ddr_miso} = '0;
    {master_select_wdata, transfer_irq_enable, global_irq_enable} = '1;
    {ddr_mosi, ddr_sck, ddr_ss, ss_gpio_level} = '1;
    rate_select = 2'b00;
    data_wdata = 8'h00;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    port_enable = 1'b1;
    pulse(master_select_wr);
    ss_gpio_level = 1'b0;
    // every rate code, both speeds, bit order flipped every other byte
    for (int i = 0; i < 8; i++) begin
      {double_speed_bit, rate_select} = 3'(i);
      bit_order_select = i[0];
      peer.tx_q = 8'hA5 ^ 8'(i);
      wr(8'h3C + 8'(i));
      wait_done();
      chkn(16 * (hv[i % 4] >> (i / 4)), n);
      chk8(i[0] ? rev(8'hA5 ^ 8'(i)) : 8'hA5 ^ 8'(i), data_rdata);
      chk8(i[0] ? rev(8'h3C + 8'(i)) : 8'h3C + 8'(i), peer.rx_q);
      chk1(1'b1, irq_req);
      chk1(clock_polarity, sck_out);
      pulse(irq_ack);
      chk1(1'b0, transfer_complete_flag);
    end
    clock_polarity = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk1(1'b1, sck_out);
    {clock_polarity, double_speed_bit, rate_select, bit_order_select} = '0;
    // second write lands while the first byte is moving
    data_wdata = 8'h11;
    data_wr = 1'b1;
    @(negedge ref_clk);
    data_wdata = 8'h22;
    @(negedge ref_clk);
    data_wr = 1'b0;
    chk1(1'b1, write_collision_flag);
    wait_done();
    chk8(8'h11, peer.rx_q);
    pulse(status_rd);
    pulse(data_rd);
    chk1(1'b0, write_collision_flag);
    chk1(1'b0, transfer_complete_flag);
    // select pulled low from outside while master
    ddr_ss = 1'b0;
    global_irq_enable = 1'b0;
    @(negedge ref_clk);
    peer.ss_n_o = 1'b0;
    @(negedge ref_clk);
    chk1(1'b0, master_select);
    chk1(1'b1, transfer_complete_flag);
    chk1(1'b1, sck_oe_n & mosi_oe_n);
    chk1(1'b0, irq_req);
    global_irq_enable = 1'b1;
    #1 chk1(1'b1, irq_req);
    peer.ss_n_o = 1'b1;
    pulse(irq_ack);
    // slave: byte loaded while deselected, then abort and overrun
    ddr_miso = 1'b1;
    wr(8'h96);
    chk1(1'b1, miso_oe_n);
    peer.send(8'h5A, 8, 1'b0, rx);
    chk8(8'h96, rx);
    chk1(1'b1, transfer_complete_flag);
    chk8(8'h5A, data_rdata);
    pulse(irq_ack);
    peer.send(8'hFF, 3, 1'b0, rx);
    // phase 1 from here: the slave echoes the byte it last took in
    clock_phase = 1'b1;
    peer.send(8'h12, 8, 1'b1, rx);
    peer.send(8'hC3, 8, 1'b1, rx);
    chk8(8'h12, rx);
    chk8(8'hC3, data_rdata);
    pulse(master_select_wr);
    chk1(1'b1, master_select);
    conclude();
  end
endmodule

// >>> verification/smsp_peer.sv
// far-side model: mode 0 slave, or master sending at clk/8 in phase 0 or 1
`timescale 1ns/1ps
module smsp_peer (
  input  wire logic ref_clk, // bench clock
  input  wire logic sck,     // resolved sck pin
  input  wire logic mosi,    // resolved mosi pin
  input  wire logic ss_n,    // resolved select pin
  input  wire logic miso,    // resolved miso pin
  output logic      sck_o,   // sck as master
  output logic      mosi_o,  // mosi as master
  output logic      ss_n_o,  // select as master
  output logic      miso_o   // miso as slave
);
  logic [7:0] tx_q = 8'h00; // byte returned as slave
  logic [7:0] rx_q = 8'h00; // byte seen as slave
  logic       act  = 1'b0;  // acting as master
  logic       m_q  = 1'b0;  // mosi bit while acting
  logic       tog  = 1'b0;  // filler for released lines
  initial begin
    sck_o  = 1'b0;
    ss_n_o = 1'b1;
  end
  // released lines wander so stale values cannot pass
  always @(posedge ref_clk) tog <= ~tog;
  assign miso_o = (ss_n | act) ? tog : tx_q[7];
  assign mosi_o = act ? m_q : tog;
  // slave role: sample on rise, shift on fall
  always @(posedge sck) if (!ss_n && !act) rx_q <= {rx_q[6:0], mosi};
  always @(negedge sck) if (!ss_n && !act) tx_q <= {tx_q[6:0], 1'b0};
  // master role: nb bits msb first in phase ph, then deselect to resync the slave
  task automatic send(input logic [7:0] tx, input int nb, input logic ph,
                      output logic [7:0] rx);
    act = 1'b1;
    ss_n_o = 1'b0;
    for (int i = 7; i > 7 - nb; i--) begin
      if (!ph) begin
        m_q = tx[i];
      end
      repeat (4) @(negedge ref_clk);
      sck_o = 1'b1;
      // phase 1 sets data up on the rising edge and samples on the falling one
      if (ph) begin
        m_q = tx[i];
      end else begin
        rx[i] = miso;
      end
      repeat (4) @(negedge ref_clk);
      sck_o = 1'b0;
      if (ph) begin
        rx[i] = miso;
      end
    end
    repeat (4) @(negedge ref_clk);
    ss_n_o = 1'b1;
    act = 1'b0;
    // keep select high a while so a back-to-back send still shows a gap
    repeat (2) @(negedge ref_clk);
  endtask
endmodule
